// >>> pkg/bmf_pkg.sv
// Constants and types for the bus-matching FIFO
package bmf_pkg;
	localparam int DEPTH_DEF = 1024;
	localparam int DATA_W = 36;
	localparam int REG_AW = 3;
	localparam int REG_DW = 32;
	// Register indices
	localparam logic [2:0] REG_STATUS = 3'h0;
	localparam logic [2:0] REG_AE_OFS = 3'h1;
	localparam logic [2:0] REG_AF_OFS = 3'h2;
	localparam logic [2:0] REG_CONFIG = 3'h3;
	// Default offsets
	localparam int PRESET_A = 8;
	localparam int PRESET_B = 16;
	localparam int PRESET_C = 64;
	// Piece widths and last-piece indices
	localparam int WORD_W = 18;
	localparam int BYTE_W = 9;
	localparam logic [1:0] LAST_LONG = 2'h0;
	localparam logic [1:0] LAST_WORD = 2'h1;
	localparam logic [1:0] LAST_BYTE = 2'h3;
	// Reset values
	localparam logic [35:0] DATA_RST = 36'h0;
	localparam logic [31:0] RDATA_RST = 32'h0;
	typedef enum logic [1:0] {SZ_LONG, SZ_WORD, SZ_BYTE} bmf_size_type;
	typedef enum logic [1:0] {LOAD_FIRST, LOAD_SECOND, LOAD_DONE} bmf_load_type;
	typedef enum logic [1:0] {METH_SERIAL, METH_PARALLEL, METH_PRESET} bmf_meth_type;
endpackage : bmf_pkg

// >>> core/bmf_fifo.sv
// Bus-matching synchronous FIFO, Port A to Port B, with mailboxes
`timescale 1ns/1ps
module bmf_fifo #(
	parameter int DEPTH = bmf_pkg::DEPTH_DEF,
	parameter int AW = $clog2(DEPTH)
) (
	// Clock and resets
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic part_rst_n_i,
	// Configuration straps
	input wire logic endian_timing_select_i,
	input wire logic bus_width_match_i,
	input wire logic bus_size_i,
	input wire logic offset_preset_sel0_i,
	input wire logic offset_preset_sel1_i,
	input wire logic serial_load_select_n_i,
	input wire logic serial_offset_in_i,
	input wire logic serial_offset_en_i,
	// Port A
	input wire logic port_a_select_n_i,
	input wire logic port_a_write_i,
	input wire logic port_a_enable_i,
	input wire logic port_a_mail_i,
	input wire logic [bmf_pkg::DATA_W-1:0] port_a_data_i,
	output logic [bmf_pkg::DATA_W-1:0] port_a_data_o,
	output logic port_a_data_oe_n_o,
	// Port B
	input wire logic port_b_select_n_i,
	input wire logic port_b_write_i,
	input wire logic port_b_enable_i,
	input wire logic port_b_mail_i,
	input wire logic [bmf_pkg::DATA_W-1:0] port_b_data_i,
	output logic [bmf_pkg::DATA_W-1:0] port_b_data_o,
	output logic port_b_data_oe_n_o,
	// Flags
	output logic fifo_full_n_o,
	output logic almost_full_n_o,
	output logic fifo_empty_n_o,
	output logic almost_empty_n_o,
	output logic mail1_full_o,
	output logic mail2_full_o,
	output logic power_down_o,
	// Register port
	input wire logic [bmf_pkg::REG_AW-1:0] reg_addr_i,
	input wire logic [bmf_pkg::REG_DW-1:0] reg_wdata_i,
	input wire logic reg_write_i,
	input wire logic reg_read_i,
	output logic [bmf_pkg::REG_DW-1:0] reg_rdata_o
);
	import bmf_pkg::*;

	// Piece of a stored word for the current bus size
	function automatic logic [35:0] piece_get(input logic [35:0] w, input bmf_size_type sz,
		input logic [1:0] idx, input logic big);
		logic [1:0] k;
		logic [35:0] res;
		k = big ? ~idx : idx;
		case (sz)
			SZ_WORD: res = {18'h0, (big ^ idx[0]) ? w[35:18] : w[17:0]};
			SZ_BYTE: res = {27'h0, w[k*BYTE_W +: BYTE_W]};
			default: res = w;
		endcase
		return res;
	endfunction : piece_get

	// Index of the last piece of a word
	function automatic logic [1:0] last_idx(input bmf_size_type sz);
		case (sz)
			SZ_WORD: return LAST_WORD;
			SZ_BYTE: return LAST_BYTE;
			default: return LAST_LONG;
		endcase
	endfunction : last_idx

	// Mask to the active bus width
	function automatic logic [35:0] width_mask(input bmf_size_type sz, input logic [35:0] d);
		case (sz)
			SZ_WORD: return {18'h0, d[WORD_W-1:0]};
			SZ_BYTE: return {27'h0, d[BYTE_W-1:0]};
			default: return d;
		endcase
	endfunction : width_mask

	// Preset offset from the two select pins
	function automatic logic [AW-1:0] preset_ofs(input logic s1, input logic s0);
		case ({s1, s0})
			2'b01: return AW'(PRESET_A);
			2'b10: return AW'(PRESET_B);
			default: return AW'(PRESET_C);
		endcase
	endfunction : preset_ofs

	// Storage, pointers and read-side state
	logic [35:0] mem_r [DEPTH];
	logic [AW:0] wr_ptr_r, rd_ptr_r;
	logic [35:0] word_r;
	logic [1:0] piece_r;
	logic hold_r;
	logic fwft_r, big_r, post_rst_r;
	bmf_meth_type meth_r;
	bmf_load_type load_r;
	logic [$clog2(2*AW+1)-1:0] ser_cnt_r;
	logic [AW-1:0] ae_ofs_r, af_ofs_r;
	logic [35:0] mail1_r, mail2_r;
	logic mail1_full_r, mail2_full_r;
	logic [35:0] a_data_r, b_data_r;
	logic [1:0] full_n_sync_r, af_n_sync_r, empty_n_sync_r, ae_n_sync_r;
	logic power_down_r;
	logic [31:0] rdata_r;

	// Port decode
	// Select and enable are both needed; the write pin picks the direction
	bmf_size_type size_w;
	logic a_acc, b_acc, a_wr, a_rd, b_wr, b_rd;
	logic a_fifo_wr, a_ofs_wr, a_mail_wr, a_mail_rd;
	logic b_fifo_rd, b_mail_wr, b_mail_rd;
	assign size_w = !bus_width_match_i ? SZ_LONG : (bus_size_i ? SZ_BYTE : SZ_WORD);
	assign a_acc = !port_a_select_n_i && port_a_enable_i;
	assign b_acc = !port_b_select_n_i && port_b_enable_i;
	assign a_wr = a_acc && port_a_write_i;
	assign a_rd = a_acc && !port_a_write_i;
	assign b_wr = b_acc && port_b_write_i;
	assign b_rd = b_acc && !port_b_write_i;
	assign a_mail_wr = a_wr && port_a_mail_i;
	assign a_mail_rd = a_rd && port_a_mail_i;
	assign b_mail_wr = b_wr && port_b_mail_i;
	assign b_mail_rd = b_rd && port_b_mail_i;
	assign a_ofs_wr = a_wr && !port_a_mail_i && meth_r == METH_PARALLEL && load_r != LOAD_DONE;

	// Occupancy
	// The extra pointer bit tells full from empty when the indices meet
	logic [AW:0] count_w, free_w;
	logic full_w, mem_empty_w;
	assign count_w = wr_ptr_r - rd_ptr_r;
	assign free_w = (AW+1)'(DEPTH) - count_w;
	assign full_w = count_w == (AW+1)'(DEPTH);
	assign mem_empty_w = count_w == '0;
	assign a_fifo_wr = a_wr && !port_a_mail_i && load_r == LOAD_DONE && !full_w;
	assign b_fifo_rd = b_rd && !port_b_mail_i;

	// Read-side decisions
	logic [1:0] last_w;
	logic at_last_w, fetch_w, step_w;
	assign last_w = last_idx(size_w);
	assign at_last_w = piece_r == last_w;
	// Fall-through fetches unasked when nothing is shown; standard only on request
	// A mailbox read owns the Port B register, so an unasked fetch waits a cycle
	assign fetch_w = !mem_empty_w && (fwft_r ? ((!hold_r && !b_mail_rd) || (b_fifo_rd && at_last_w))
		: (b_fifo_rd && !hold_r));
	assign step_w = b_fifo_rd && hold_r && !fetch_w;

	// Raw flags
	logic empty_n_w, full_n_w, ae_n_w, af_n_w;
	assign empty_n_w = fwft_r ? hold_r : (!mem_empty_w || hold_r);
	assign full_n_w = !full_w && load_r == LOAD_DONE;
	assign ae_n_w = count_w > (AW+1)'(ae_ofs_r);
	assign af_n_w = free_w > (AW+1)'(af_ofs_r);

	// Storage write
	// No reset on the array: the pointers alone say which words are valid
	always_ff @(posedge clk_i) begin
		if (a_fifo_wr) begin
			mem_r[wr_ptr_r[AW-1:0]] <= port_a_data_i;
		end
	end

	// Pointers; wrap through the extra bit
	// Partial reset flushes here but leaves straps and offsets alone
	always_ff @(posedge clk_i) begin
		if (!nrst_i || !part_rst_n_i) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
		end else begin
			wr_ptr_r <= wr_ptr_r + (AW+1)'(a_fifo_wr);
			rd_ptr_r <= rd_ptr_r + (AW+1)'(fetch_w);
		end
	end

	// Word in hand and piece index
	always_ff @(posedge clk_i) begin
		if (!nrst_i || !part_rst_n_i) begin
			word_r <= DATA_RST;
			piece_r <= 2'h0;
			hold_r <= 1'b0;
		end else if (fetch_w) begin
			word_r <= mem_r[rd_ptr_r[AW-1:0]];
			piece_r <= fwft_r ? 2'h0 : 2'h1;
			hold_r <= fwft_r || last_w != LAST_LONG;
		end else if (step_w) begin
			piece_r <= at_last_w ? 2'h0 : piece_r + 2'h1;
			hold_r <= !at_last_w;
		end
	end

	// Port B output register
	always_ff @(posedge clk_i) begin
		if (!nrst_i || !part_rst_n_i) begin
			b_data_r <= DATA_RST;
		end else if (b_mail_rd) begin
			b_data_r <= mail1_r;
		end else if (fetch_w) begin
			b_data_r <= piece_get(mem_r[rd_ptr_r[AW-1:0]], size_w, 2'h0, big_r);
		end else if (step_w && (!fwft_r || !at_last_w)) begin
			b_data_r <= piece_get(word_r, size_w, fwft_r ? piece_r + 2'h1 : piece_r, big_r);
		end
	end

	// Straps: endian during reset, timing mode on first edge after
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			big_r <= endian_timing_select_i;
			fwft_r <= 1'b0;
			post_rst_r <= 1'b0;
		end else if (!post_rst_r) begin
			fwft_r <= !endian_timing_select_i;
			post_rst_r <= 1'b1;
		end
	end

	// Offset method and values; software writes override
	// Serial load shifts X then Y through one chain, most significant bit first
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			meth_r <= !serial_load_select_n_i ? METH_SERIAL
				: ({offset_preset_sel1_i, offset_preset_sel0_i} == 2'b00 ? METH_PARALLEL : METH_PRESET);
			load_r <= (serial_load_select_n_i && {offset_preset_sel1_i, offset_preset_sel0_i} != 2'b00)
				? LOAD_DONE : LOAD_FIRST;
			ae_ofs_r <= preset_ofs(offset_preset_sel1_i, offset_preset_sel0_i);
			af_ofs_r <= preset_ofs(offset_preset_sel1_i, offset_preset_sel0_i);
			ser_cnt_r <= '0;
		end else if (reg_write_i && reg_addr_i == REG_AE_OFS) begin
			ae_ofs_r <= reg_wdata_i[AW-1:0];
		end else if (reg_write_i && reg_addr_i == REG_AF_OFS) begin
			af_ofs_r <= reg_wdata_i[AW-1:0];
		end else if (a_ofs_wr) begin
			if (load_r == LOAD_FIRST) begin
				ae_ofs_r <= port_a_data_i[AW-1:0];
				load_r <= LOAD_SECOND;
			end else begin
				af_ofs_r <= port_a_data_i[AW-1:0];
				load_r <= LOAD_DONE;
			end
		end else if (meth_r == METH_SERIAL && load_r != LOAD_DONE && serial_offset_en_i) begin
			{ae_ofs_r, af_ofs_r} <= {ae_ofs_r[AW-2:0], af_ofs_r, serial_offset_in_i};
			ser_cnt_r <= ser_cnt_r + 1'b1;
			if (ser_cnt_r == ($bits(ser_cnt_r))'(2*AW-1)) begin
				load_r <= LOAD_DONE;
			end
		end
	end

	// Mailbox 1: Port A to Port B; a new write wins over a read
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			mail1_r <= DATA_RST;
			mail1_full_r <= 1'b0;
		end else if (a_mail_wr) begin
			mail1_r <= width_mask(size_w, port_a_data_i);
			mail1_full_r <= 1'b1;
		end else if (b_mail_rd) begin
			mail1_full_r <= 1'b0;
		end
	end

	// Mailbox 2: Port B to Port A; a new write wins over a read
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			mail2_r <= DATA_RST;
			mail2_full_r <= 1'b0;
		end else if (b_mail_wr) begin
			mail2_r <= width_mask(size_w, port_b_data_i);
			mail2_full_r <= 1'b1;
		end else if (a_mail_rd) begin
			mail2_full_r <= 1'b0;
		end
	end

	// Port A output register
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			a_data_r <= DATA_RST;
		end else if (a_mail_rd) begin
			a_data_r <= mail2_r;
		end
	end

	// Two-stage flag pipelines toward each port
	// Flags lag the counters by two edges; a user must allow for that
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			full_n_sync_r <= 2'h0;
			af_n_sync_r <= 2'h0;
			empty_n_sync_r <= 2'h0;
			ae_n_sync_r <= 2'h0;
		end else begin
			full_n_sync_r <= {full_n_sync_r[0], full_n_w};
			af_n_sync_r <= {af_n_sync_r[0], af_n_w};
			empty_n_sync_r <= {empty_n_sync_r[0], empty_n_w};
			ae_n_sync_r <= {ae_n_sync_r[0], ae_n_w};
		end
	end

	// Idle tracking
	// The output drops at once on activity; the register only keeps idle history
	logic active_w;
	assign active_w = a_acc || b_acc || serial_offset_en_i || reg_write_i || reg_read_i;
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			power_down_r <= 1'b0;
		end else begin
			power_down_r <= !active_w;
		end
	end

	// Register read mux
	// Unmapped indices read as zero
	logic [31:0] status_w, config_w, rsel_w;
	assign status_w = 32'({count_w, 10'h0, mail2_full_r, mail1_full_r, af_n_w, ae_n_w, full_n_w, empty_n_w});
	assign config_w = {24'h0, load_r, meth_r, size_w, big_r, fwft_r};
	assign rsel_w = reg_addr_i == REG_STATUS ? status_w
		: reg_addr_i == REG_AE_OFS ? 32'(ae_ofs_r)
		: reg_addr_i == REG_AF_OFS ? 32'(af_ofs_r)
		: reg_addr_i == REG_CONFIG ? config_w : RDATA_RST;
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			rdata_r <= RDATA_RST;
		end else begin
			rdata_r <= reg_read_i ? rsel_w : RDATA_RST;
		end
	end

	// Outputs; ready flags allow width and fall-through depth cascades
	assign port_a_data_o = a_data_r;
	assign port_b_data_o = b_data_r;
	assign port_a_data_oe_n_o = !(!port_a_select_n_i && !port_a_write_i);
	assign port_b_data_oe_n_o = !(!port_b_select_n_i && !port_b_write_i);
	assign fifo_full_n_o = full_n_sync_r[1];
	assign almost_full_n_o = af_n_sync_r[1];
	assign fifo_empty_n_o = empty_n_sync_r[1];
	assign almost_empty_n_o = ae_n_sync_r[1];
	assign mail1_full_o = mail1_full_r;
	assign mail2_full_o = mail2_full_r;
	assign power_down_o = power_down_r && !active_w;
	assign reg_rdata_o = rdata_r;
endmodule : bmf_fifo

// >>> bench/bmf_fifo_chk.sv
// Port-level assertions for the bus-matching FIFO
`timescale 1ns/1ps
module bmf_fifo_chk #(
	parameter int DEPTH = 1024
) (
	// Clock, resets, timing strap
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic part_rst_n_i,
	input wire logic endian_timing_select_i,
	// Port A
	input wire logic port_a_select_n_i,
	input wire logic port_a_write_i,
	input wire logic port_a_enable_i,
	input wire logic port_a_mail_i,
	input wire logic port_a_data_oe_n_o,
	// Port B
	input wire logic port_b_select_n_i,
	input wire logic port_b_write_i,
	input wire logic port_b_enable_i,
	input wire logic port_b_mail_i,
	input wire logic [35:0] port_b_data_o,
	input wire logic port_b_data_oe_n_o,
	// Flags and register port
	input wire logic fifo_empty_n_o,
	input wire logic mail1_full_o,
	input wire logic mail2_full_o,
	input wire logic power_down_o,
	input wire logic reg_read_i,
	input wire logic [31:0] reg_rdata_o
);
	import bmf_pkg::*;
	// Decoded port requests
	wire a_act = !port_a_select_n_i && port_a_enable_i;
	wire b_act = !port_b_select_n_i && port_b_enable_i;
	wire a_mw = a_act && port_a_write_i && port_a_mail_i;
	wire b_mr = b_act && !port_b_write_i && port_b_mail_i;
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!nrst_i);
	a_oe_a_drive: assert property (port_a_data_oe_n_o == (port_a_select_n_i || port_a_write_i))
		else $error("port A drive enable wrong");
	a_oe_b_drive: assert property (port_b_data_oe_n_o == (port_b_select_n_i || port_b_write_i))
		else $error("port B drive enable wrong");
	a_mail_one_set: assert property (a_mw |=> mail1_full_o)
		else $error("mail1 flag not set");
	a_mail_two_set: assert property (b_act && port_b_write_i && port_b_mail_i |=> mail2_full_o)
		else $error("mail2 flag not set");
	a_mail_one_clear: assert property (b_mr && !a_mw && mail1_full_o |=> !mail1_full_o)
		else $error("mail1 flag not cleared");
	a_wake_on_use: assert property (a_act || b_act |-> !power_down_o)
		else $error("power down while active");
	a_std_out_hold: assert property (port_b_select_n_i && endian_timing_select_i && part_rst_n_i
		|=> $stable(port_b_data_o))
		else $error("port B output moved without read");
	a_part_flush: assert property (!part_rst_n_i |-> ##[1:4] !fifo_empty_n_o)
		else $error("partial reset left data");
	a_rdata_idle: assert property (!reg_read_i |=> reg_rdata_o == 32'h0)
		else $error("read data outside read cycle");
endmodule : bmf_fifo_chk

bind bmf_fifo bmf_fifo_chk #(.DEPTH(DEPTH)) chk_u (.clk_i, .nrst_i, .part_rst_n_i, .endian_timing_select_i,
	.port_a_select_n_i, .port_a_write_i, .port_a_enable_i, .port_a_mail_i, .port_a_data_oe_n_o,
	.port_b_select_n_i, .port_b_write_i, .port_b_enable_i, .port_b_mail_i, .port_b_data_o, .port_b_data_oe_n_o,
	.fifo_empty_n_o, .mail1_full_o, .mail2_full_o, .power_down_o, .reg_read_i, .reg_rdata_o);

// >>> bench/bmf_b_host.sv
// Port B host model: reads, mail reads and mail writes
`timescale 1ns/1ps
module bmf_b_host (
	// Clock and bench commands
	input wire logic clk_i,
	input wire logic rd_i,
	input wire logic wr_i,
	input wire logic mail_i,
	input wire logic [35:0] data_i,
	// Port B controls
	output logic sel_n_o = 1'b1,
	output logic en_o = 1'b0,
	output logic wr_o = 1'b0,
	output logic mail_o = 1'b0,
	output logic [35:0] data_o = 36'h0
);
	// One-cycle request after the edge; released data inverts
	always @(posedge clk_i) begin
		sel_n_o <= !(rd_i | wr_i);
		en_o <= rd_i | wr_i;
		wr_o <= wr_i;
		mail_o <= mail_i;
		data_o <= wr_i ? data_i : ~data_o;
	end
endmodule : bmf_b_host

// >>> bench/bmf_fifo_bench.sv
// Self-checking bench for the bus-matching FIFO
`timescale 1ns/1ps
`define CK(n, e, s) begin checked++; if ((s) !== (e)) begin failures++; $display("BAD %s exp %h got %h", n, e, s); end end
module bmf_fifo_bench;
	import bmf_pkg::*;
	localparam int DEPTH = 128;
	localparam int AW = $clog2(DEPTH);
	logic clk_i = 0, nrst_i = 0, part_rst_n_i = 1, endian_timing_select_i = 1, bus_width_match_i = 0;
	logic bus_size_i = 0, offset_preset_sel0_i = 1, offset_preset_sel1_i = 0, port_a_select_n_i = 1;
	logic port_a_write_i = 0, port_a_enable_i = 0, port_a_mail_i = 0, reg_write_i = 0, reg_read_i = 0;
	logic b_rd = 0, b_wr = 0, b_mail = 0, port_b_select_n_i, port_b_write_i, port_b_enable_i, port_b_mail_i;
	logic port_a_data_oe_n_o, port_b_data_oe_n_o, fifo_full_n_o, almost_full_n_o, fifo_empty_n_o;
	logic almost_empty_n_o, mail1_full_o, mail2_full_o, power_down_o;
	logic [35:0] port_a_data_i = 0, port_a_data_o, port_b_data_i, port_b_data_o, b_data = 0, w, mk, ex;
	logic serial_load_select_n_i = 1, serial_offset_in_i = 0, serial_offset_en_i = 0;
	logic [2*AW-1:0] ofs;
	logic [2:0] reg_addr_i = 0;
	logic [31:0] reg_wdata_i = 0, reg_rdata_o, rd;
	logic [35:0] q[$];
	int failures = 0, checked = 0, cyc = 0;
	// Design and Port B host
	bmf_fifo #(.DEPTH(DEPTH)) dut_u (.clk_i, .nrst_i, .part_rst_n_i, .endian_timing_select_i, .bus_width_match_i,
		.bus_size_i, .offset_preset_sel0_i, .offset_preset_sel1_i, .serial_load_select_n_i,
		.serial_offset_in_i, .serial_offset_en_i, .port_a_select_n_i, .port_a_write_i,
		.port_a_enable_i, .port_a_mail_i, .port_a_data_i, .port_a_data_o, .port_a_data_oe_n_o,
		.port_b_select_n_i, .port_b_write_i, .port_b_enable_i, .port_b_mail_i, .port_b_data_i, .port_b_data_o,
		.port_b_data_oe_n_o, .fifo_full_n_o, .almost_full_n_o, .fifo_empty_n_o, .almost_empty_n_o,
		.mail1_full_o, .mail2_full_o, .power_down_o, .reg_addr_i, .reg_wdata_i, .reg_write_i, .reg_read_i,
		.reg_rdata_o);
	bmf_b_host host_u (.clk_i, .rd_i(b_rd), .wr_i(b_wr), .mail_i(b_mail), .data_i(b_data),
		.sel_n_o(port_b_select_n_i), .en_o(port_b_enable_i), .wr_o(port_b_write_i), .mail_o(port_b_mail_i),
		.data_o(port_b_data_i));
	// Clock and hang guard
	always #2.5 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 10000) begin
			failures++;
			results();
		end
	end
	task automatic results();
		$display("Counts: %0d checked, %0d failures", checked, failures);
		if (failures == 0 && checked > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : results
	// Full reset with straps; timing level applied at release
	task automatic boot(logic er, logic eo, logic bm, logic sz, logic [1:0] fs);
		@(posedge clk_i);
		nrst_i <= 0;
		endian_timing_select_i <= er;
		bus_width_match_i <= bm;
		bus_size_i <= sz;
		{offset_preset_sel1_i, offset_preset_sel0_i} <= fs;
		repeat (2) @(posedge clk_i);
		nrst_i <= 1;
		endian_timing_select_i <= eo;
		repeat (6) @(posedge clk_i);
	endtask : boot
	// Port A cycle; released data inverts
	task automatic pa(logic wr, logic m, logic [35:0] d);
		@(posedge clk_i);
		port_a_select_n_i <= 0;
		port_a_enable_i <= 1;
		port_a_write_i <= wr;
		port_a_mail_i <= m;
		port_a_data_i <= d;
		@(posedge clk_i);
		port_a_select_n_i <= 1;
		port_a_enable_i <= 0;
		port_a_data_i <= ~d;
	endtask : pa
	// Port B cycle through the host, settles answer
	task automatic pb(logic wr, logic m, logic [35:0] d);
		@(posedge clk_i);
		b_rd <= !wr;
		b_wr <= wr;
		b_mail <= m;
		b_data <= d;
		@(posedge clk_i);
		b_rd <= 0;
		b_wr <= 0;
		repeat (2) @(posedge clk_i);
		#1;
	endtask : pb
	// Register cycle; read data taken in the following cycle
	task automatic rg(logic wr, logic [2:0] a, logic [31:0] d);
		@(posedge clk_i);
		reg_write_i <= wr;
		reg_read_i <= !wr;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		@(posedge clk_i);
		reg_write_i <= 0;
		reg_read_i <= 0;
		#1 rd = reg_rdata_o;
	endtask : rg
	// Expected piece i of a word for byte or word width
	function automatic logic [35:0] piece(logic [35:0] v, logic sz, logic big, int i);
		int k;
		k = big ? (sz ? 3 - i : 1 - i) : i;
		return sz ? 36'(v[k * 9 +: 9]) : 36'(v[k * 18 +: 18]);
	endfunction : piece
	// Test sequence
	initial begin
		void'($urandom(82382));
		boot(1, 1, 0, 0, 2'b01);
		rg(0, REG_AE_OFS, 0);
		`CK("preset x", 32'd8, rd)
		rg(1, REG_AE_OFS, 32'd11);
		rg(0, REG_AE_OFS, 0);
		`CK("x reg", 32'd11, rd)
		rg(1, REG_AE_OFS, 32'd8);
		rg(0, 3'h5, 0);
		`CK("unmapped", 32'h0, rd)
		`CK("full_n", 1'b1, fifo_full_n_o)
		for (int i = 0; i < DEPTH; i++) begin
			w = 36'({$urandom(), $urandom()});
			q.push_back(w);
			pa(1, 0, w);
			if (i == 0) begin
				repeat (4) @(posedge clk_i);
				#1 `CK("no fall", 36'h0, port_b_data_o)
				`CK("empty_n", 1'b1, fifo_empty_n_o)
				`CK("ae low", 1'b0, almost_empty_n_o)
			end
			if (i == 7 || i == 8 || i == DEPTH - 10 || i == DEPTH - 9) begin
				repeat (4) @(posedge clk_i);
				#1 `CK("ae edge", i > 7, almost_empty_n_o)
				`CK("af edge", i < DEPTH - 9, almost_full_n_o)
			end
		end
		repeat (5) @(posedge clk_i);
		`CK("full", 1'b0, fifo_full_n_o)
		`CK("af low", 1'b0, almost_full_n_o)
		`CK("ae high", 1'b1, almost_empty_n_o)
		pa(1, 0, 36'h0);
		while (q.size() > 0) begin
			w = q.pop_front();
			pb(0, 0, 0);
			`CK("word", w, port_b_data_o)
		end
		repeat (4) @(posedge clk_i);
		`CK("empty", 1'b0, fifo_empty_n_o)
		pb(0, 0, 0);
		`CK("empty read", w, port_b_data_o)
		w = 36'({$urandom(), $urandom()});
		q.push_back(w);
		pa(1, 0, w);
		for (int i = 0; i < 3; i++) begin
			w = 36'({$urandom(), $urandom()});
			q.push_back(w);
			ex = q.pop_front();
			// Read and write land on the same edge
			fork
				pb(0, 0, 0);
				begin
					@(posedge clk_i);
					pa(1, 0, w);
				end
			join
			`CK("wrap", ex, port_b_data_o)
		end
		pa(1, 0, w);
		pa(1, 0, w);
		@(posedge clk_i);
		part_rst_n_i <= 0;
		repeat (2) @(posedge clk_i);
		part_rst_n_i <= 1;
		repeat (6) @(posedge clk_i);
		`CK("flushed", 1'b0, fifo_empty_n_o)
		rg(0, REG_AE_OFS, 0);
		`CK("kept x", 32'd8, rd)
		$display("test standard done");
		// Serial offset load, then parallel load over Port A
		serial_load_select_n_i <= 0;
		boot(1, 1, 0, 0, 2'b01);
		`CK("load wait", 1'b0, fifo_full_n_o)
		#1 `CK("asleep", 1'b1, power_down_o)
		ofs = (2 * AW)'($urandom());
		for (int j = 2 * AW - 1; j >= 0; j--) begin
			@(posedge clk_i);
			serial_offset_en_i <= 1;
			serial_offset_in_i <= ofs[j];
		end
		@(posedge clk_i);
		serial_offset_en_i <= 0;
		serial_load_select_n_i <= 1;
		repeat (4) @(posedge clk_i);
		`CK("loaded", 1'b1, fifo_full_n_o)
		rg(0, REG_AE_OFS, 0);
		`CK("serial x", 32'(ofs[2 * AW - 1:AW]), rd)
		rg(0, REG_AF_OFS, 0);
		`CK("serial y", 32'(ofs[AW - 1:0]), rd)
		boot(1, 1, 0, 0, 2'b00);
		ofs = (2 * AW)'($urandom());
		pa(1, 0, 36'(ofs[2 * AW - 1:AW]));
		`CK("load wait", 1'b0, fifo_full_n_o)
		pa(1, 0, 36'(ofs[AW - 1:0]));
		repeat (4) @(posedge clk_i);
		`CK("loaded", 1'b1, fifo_full_n_o)
		`CK("no store", 1'b0, fifo_empty_n_o)
		rg(0, REG_AE_OFS, 0);
		`CK("parallel x", 32'(ofs[2 * AW - 1:AW]), rd)
		rg(0, REG_AF_OFS, 0);
		`CK("parallel y", 32'(ofs[AW - 1:0]), rd)
		$display("test load done");
		for (int c = 0; c < 2; c++) begin
			boot(1'(c), 0, 1, !c, c ? 2'b11 : 2'b10);
			mk = c ? 36'h3ffff : 36'h1ff;
			rg(0, REG_AE_OFS, 0);
			`CK("preset x", c ? 32'd64 : 32'd16, rd)
			w = 36'({$urandom(), $urandom()});
			pa(1, 0, w);
			repeat (6) @(posedge clk_i);
			#1 `CK("fall", piece(w, !c, 1'(c), 0), port_b_data_o)
			`CK("out ready", 1'b1, fifo_empty_n_o)
			for (int i = 1; i < (c ? 2 : 4); i++) begin
				pb(0, 0, 0);
				`CK("piece", piece(w, !c, 1'(c), i), port_b_data_o)
			end
			pa(1, 1, w);
			#1 `CK("mail1 set", 1'b1, mail1_full_o)
			pb(0, 1, 0);
			`CK("mail1 data", w & mk, port_b_data_o)
			`CK("mail1 clr", 1'b0, mail1_full_o)
			pb(1, 1, ~w);
			`CK("mail2 set", 1'b1, mail2_full_o)
			pa(0, 1, 0);
			#1 `CK("mail2 data", ~w & mk, port_a_data_o)
			$display("test narrow %0d done", c);
		end
		results();
	end
endmodule : bmf_fifo_bench
